// [hdl/mbs_motor_brake_sequencer.sv]
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mbs_motor_brake_sequencer #(
   parameter int unsigned TICK_CYCLES = mbs_pkg::TICK_CYCLES
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [mbs_pkg::AW-1:0]     reg_addr,
   input  wire logic [mbs_pkg::DW-1:0]     reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [mbs_pkg::DW-1:0]     reg_rdata,
   input  wire logic                       run_cmd,
   input  wire logic [mbs_pkg::DW-1:0]     out_freq_in,
   input  wire logic [mbs_pkg::DW-1:0]     motor_current_in,
   input  wire logic [mbs_pkg::N_DIN-1:0]  din,
   output logic      [mbs_pkg::N_DOUT-1:0] dout,
   output logic      [mbs_pkg::DW-1:0]     freq_target_out,
   output logic                            brake_release_out,
   output logic                            brake_fault_out,
   output logic      [mbs_pkg::FW-1:0]     fault_code_out
);
   localparam int unsigned DW = mbs_pkg::DW;
   localparam int unsigned FW = mbs_pkg::FW;
   localparam logic [mbs_pkg::PRE_W-1:0] TICK_LAST = mbs_pkg::PRE_W'(TICK_CYCLES - 1);

   logic [FW-1:0]         ctrl_ff;
   logic [DW-1:0]         rel_dly_ff;
   logic [DW-1:0]         acc_dly_ff;
   logic [DW-1:0]         stop_dly_ff;
   logic [DW-1:0]         conf_to_ff;
   logic [DW-1:0]         bfreq_ff;
   logic [DW-1:0]         cur_min_ff;
   logic [DW-1:0]         setpt_ff;
   logic [FW-1:0]         in_fn_ff  [mbs_pkg::N_DIN];
   logic [FW-1:0]         out_fn_ff [mbs_pkg::N_DOUT];
   logic [mbs_pkg::N_DIN-1:0] conf_hit;
   logic                  confirm;
   logic                  enabled;
   logic                  fault_clr;
   logic [mbs_pkg::PRE_W-1:0] pre_ff;
   logic                  tick;
   logic [DW-1:0]         tmr_ff;
   logic                  expired;
   mbs_pkg::mbs_state_t   state_ff;
   logic [DW-1:0]         target_ff;
   logic                  release_ff;
   logic                  fault_ff;
   logic [FW-1:0]         code_ff;
   logic [mbs_pkg::N_DOUT-1:0] dout_ff;
   logic [DW-1:0]         rdata_ff;
   logic [DW-1:0]         nxt_rdata;

   // settings above their range are clamped to the top value on write
   function automatic logic [DW-1:0] clamp(input logic [DW-1:0] v, input logic [DW-1:0] m);
      return (v > m) ? m : v;
   endfunction

   function automatic logic wr_at(input logic [mbs_pkg::AW-1:0] a);
      return reg_wr && (reg_addr == a);
   endfunction

   assign enabled   = (ctrl_ff == mbs_pkg::CTRL_ON);
   assign fault_clr = wr_at(mbs_pkg::A_STATUS) && reg_wdata[mbs_pkg::CLR_BIT];

   // scalar settings; delays hold 10 ms ticks, so 500 means 5 s
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff     <= mbs_pkg::CTRL_OFF;
         rel_dly_ff  <= mbs_pkg::DELAY_RST;
         acc_dly_ff  <= mbs_pkg::DELAY_RST;
         stop_dly_ff <= mbs_pkg::DELAY_RST;
         conf_to_ff  <= mbs_pkg::DELAY_RST;
         bfreq_ff    <= mbs_pkg::FREQ_ZERO;
         cur_min_ff  <= mbs_pkg::RATED_CURRENT;
         setpt_ff    <= mbs_pkg::FREQ_ZERO;
      end else begin
         if (wr_at(mbs_pkg::A_CTRL)) begin
            ctrl_ff <= reg_wdata[FW-1:0];
         end
         if (wr_at(mbs_pkg::A_REL_DLY)) begin
            rel_dly_ff <= clamp(reg_wdata, mbs_pkg::DELAY_MAX_TICKS);
         end
         if (wr_at(mbs_pkg::A_ACC_DLY)) begin
            acc_dly_ff <= clamp(reg_wdata, mbs_pkg::DELAY_MAX_TICKS);
         end
         if (wr_at(mbs_pkg::A_STOP_DLY)) begin
            stop_dly_ff <= clamp(reg_wdata, mbs_pkg::DELAY_MAX_TICKS);
         end
         if (wr_at(mbs_pkg::A_CONF_TO)) begin
            conf_to_ff <= clamp(reg_wdata, mbs_pkg::DELAY_MAX_TICKS);
         end
         if (wr_at(mbs_pkg::A_BFREQ)) begin
            bfreq_ff <= clamp(reg_wdata, mbs_pkg::FREQ_MAX);
         end
         if (wr_at(mbs_pkg::A_CUR_MIN)) begin
            cur_min_ff <= clamp(reg_wdata, mbs_pkg::RATED_CURRENT << 1);
         end
         if (wr_at(mbs_pkg::A_SETPT)) begin
            setpt_ff <= clamp(reg_wdata, mbs_pkg::FREQ_MAX);
         end
      end
   end

   // input function selectors; several inputs set to confirm are or-ed
   genvar gi;
   generate
      for (gi = 0; gi < mbs_pkg::N_DIN; gi++) begin : g_din
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               in_fn_ff[gi] <= mbs_pkg::FN_NONE;
            end else if (wr_at(mbs_pkg::A_IN_FN + mbs_pkg::AW'(gi))) begin
               in_fn_ff[gi] <= reg_wdata[FW-1:0];
            end
         end
         assign conf_hit[gi] = din[gi] && (in_fn_ff[gi] == mbs_pkg::FN_CONFIRM);
      end
   endgenerate
   assign confirm = |conf_hit;

   // output function selectors and the routed output pins
   generate
      for (gi = 0; gi < mbs_pkg::N_DOUT; gi++) begin : g_dout
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               out_fn_ff[gi] <= mbs_pkg::FN_NONE;
               dout_ff[gi]   <= 1'b0;
            end else begin
               if (wr_at(mbs_pkg::A_OUT_FN + mbs_pkg::AW'(gi))) begin
                  out_fn_ff[gi] <= reg_wdata[FW-1:0];
               end
               dout_ff[gi] <= ((out_fn_ff[gi] == mbs_pkg::FN_RELEASE) && release_ff)
                           || ((out_fn_ff[gi] == mbs_pkg::FN_FAULT) && fault_ff);
            end
         end
      end
   endgenerate

   assign tick    = (pre_ff == TICK_LAST);
   assign expired = (tmr_ff == mbs_pkg::DELAY_RST);

   // brake sequence with its delay timer; a load restarts the prescaler so
   // a delay of n ticks lasts exactly n * 10 ms, and zero expires at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= mbs_pkg::MBS_IDLE;
         target_ff  <= mbs_pkg::FREQ_ZERO;
         release_ff <= 1'b0;
         fault_ff   <= 1'b0;
         code_ff    <= mbs_pkg::CODE_NONE;
         pre_ff     <= '0;
         tmr_ff     <= mbs_pkg::DELAY_RST;
      end else begin
         pre_ff <= tick ? '0 : pre_ff + 1'b1;
         if (tick && !expired) begin
            tmr_ff <= tmr_ff - 1'b1;
         end
         case (state_ff)
            mbs_pkg::MBS_IDLE: begin
               release_ff <= 1'b0;
               target_ff  <= mbs_pkg::FREQ_ZERO;
               if (run_cmd && enabled) begin
                  target_ff <= bfreq_ff;
                  state_ff  <= mbs_pkg::MBS_ACC_BRK;
               end else if (run_cmd) begin
                  state_ff <= mbs_pkg::MBS_PLAIN;
               end
            end
            mbs_pkg::MBS_PLAIN: begin
               target_ff <= run_cmd ? setpt_ff : mbs_pkg::FREQ_ZERO;
               if (!run_cmd) begin
                  state_ff <= mbs_pkg::MBS_IDLE;
               end
            end
            mbs_pkg::MBS_ACC_BRK: begin
               if (!run_cmd) begin
                  target_ff <= mbs_pkg::FREQ_ZERO;
                  state_ff  <= mbs_pkg::MBS_DEC_ZERO;
               end else if (out_freq_in == target_ff) begin
                  tmr_ff   <= rel_dly_ff;
                  pre_ff   <= '0;
                  state_ff <= mbs_pkg::MBS_REL_WAIT;
               end
            end
            mbs_pkg::MBS_REL_WAIT: begin
               if (!run_cmd) begin
                  target_ff <= mbs_pkg::FREQ_ZERO;
                  state_ff  <= mbs_pkg::MBS_DEC_ZERO;
               end else if (expired && motor_current_in >= cur_min_ff) begin
                  release_ff <= 1'b1;
                  tmr_ff     <= conf_to_ff;
                  pre_ff     <= '0;
                  state_ff   <= mbs_pkg::MBS_CONF_REL;
               end else if (expired) begin
                  fault_ff  <= 1'b1;
                  code_ff   <= mbs_pkg::CODE_RELEASE;
                  target_ff <= mbs_pkg::FREQ_ZERO;
                  state_ff  <= mbs_pkg::MBS_FAULT;
               end
            end
            mbs_pkg::MBS_CONF_REL: begin
               // a confirm in the expiry cycle still counts as in time
               if (!run_cmd) begin
                  release_ff <= 1'b0;
                  tmr_ff     <= conf_to_ff;
                  pre_ff     <= '0;
                  state_ff   <= mbs_pkg::MBS_CONF_APPLY;
               end else if (confirm) begin
                  tmr_ff   <= acc_dly_ff;
                  pre_ff   <= '0;
                  state_ff <= mbs_pkg::MBS_ACC_WAIT;
               end else if (expired) begin
                  release_ff <= 1'b0;
                  fault_ff   <= 1'b1;
                  code_ff    <= mbs_pkg::CODE_RELEASE;
                  target_ff  <= mbs_pkg::FREQ_ZERO;
                  state_ff   <= mbs_pkg::MBS_FAULT;
               end
            end
            mbs_pkg::MBS_ACC_WAIT: begin
               if (!run_cmd) begin
                  release_ff <= 1'b0;
                  tmr_ff     <= conf_to_ff;
                  pre_ff     <= '0;
                  state_ff   <= mbs_pkg::MBS_CONF_APPLY;
               end else if (expired) begin
                  target_ff <= setpt_ff;
                  state_ff  <= mbs_pkg::MBS_RUN;
               end
            end
            mbs_pkg::MBS_RUN: begin
               target_ff <= setpt_ff;
               if (!run_cmd) begin
                  target_ff <= bfreq_ff;
                  state_ff  <= mbs_pkg::MBS_DEC_BRK;
               end
            end
            mbs_pkg::MBS_DEC_BRK: begin
               if (out_freq_in == target_ff) begin
                  release_ff <= 1'b0;
                  tmr_ff     <= conf_to_ff;
                  pre_ff     <= '0;
                  state_ff   <= mbs_pkg::MBS_CONF_APPLY;
               end
            end
            mbs_pkg::MBS_CONF_APPLY: begin
               // target stays at brake frequency while waiting
               if (!confirm) begin
                  tmr_ff   <= stop_dly_ff;
                  pre_ff   <= '0;
                  state_ff <= mbs_pkg::MBS_STOP_WAIT;
               end else if (expired) begin
                  release_ff <= 1'b0;
                  fault_ff   <= 1'b1;
                  code_ff    <= mbs_pkg::CODE_APPLY;
                  target_ff  <= mbs_pkg::FREQ_ZERO;
                  state_ff   <= mbs_pkg::MBS_FAULT;
               end
            end
            mbs_pkg::MBS_STOP_WAIT: begin
               if (expired) begin
                  target_ff <= mbs_pkg::FREQ_ZERO;
                  state_ff  <= mbs_pkg::MBS_DEC_ZERO;
               end
            end
            mbs_pkg::MBS_DEC_ZERO: begin
               if (out_freq_in == mbs_pkg::FREQ_ZERO) begin
                  state_ff <= mbs_pkg::MBS_IDLE;
               end
            end
            mbs_pkg::MBS_FAULT: begin
               // held until software clears it with the run command gone,
               // so a standing run command cannot restart a faulted drive
               release_ff <= 1'b0;
               target_ff  <= mbs_pkg::FREQ_ZERO;
               if (fault_clr && !run_cmd) begin
                  fault_ff <= 1'b0;
                  code_ff  <= mbs_pkg::CODE_NONE;
                  state_ff <= mbs_pkg::MBS_IDLE;
               end
            end
            default: begin
               state_ff <= mbs_pkg::MBS_IDLE;
            end
         endcase
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      nxt_rdata = '0;
      case (reg_addr)
         mbs_pkg::A_CTRL:     nxt_rdata = DW'(ctrl_ff);
         mbs_pkg::A_REL_DLY:  nxt_rdata = rel_dly_ff;
         mbs_pkg::A_ACC_DLY:  nxt_rdata = acc_dly_ff;
         mbs_pkg::A_STOP_DLY: nxt_rdata = stop_dly_ff;
         mbs_pkg::A_CONF_TO:  nxt_rdata = conf_to_ff;
         mbs_pkg::A_BFREQ:    nxt_rdata = bfreq_ff;
         mbs_pkg::A_CUR_MIN:  nxt_rdata = cur_min_ff;
         mbs_pkg::A_SETPT:    nxt_rdata = setpt_ff;
         mbs_pkg::A_STATUS: begin
            nxt_rdata[mbs_pkg::ST_REL_BIT]  = release_ff;
            nxt_rdata[mbs_pkg::ST_FLT_BIT]  = fault_ff;
            nxt_rdata[mbs_pkg::ST_CONF_BIT] = confirm;
            nxt_rdata[mbs_pkg::ST_STATE_LSB +: 4] = state_ff;
            nxt_rdata[mbs_pkg::ST_CODE_LSB +: FW] = code_ff;
         end
         default: begin
            for (int i = 0; i < mbs_pkg::N_DIN; i++) begin
               if (reg_addr == mbs_pkg::A_IN_FN + mbs_pkg::AW'(i)) begin
                  nxt_rdata = DW'(in_fn_ff[i]);
               end
            end
            for (int i = 0; i < mbs_pkg::N_DOUT; i++) begin
               if (reg_addr == mbs_pkg::A_OUT_FN + mbs_pkg::AW'(i)) begin
                  nxt_rdata = DW'(out_fn_ff[i]);
               end
            end
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= reg_rd ? nxt_rdata : '0;
      end
   end

   assign reg_rdata         = rdata_ff;
   assign dout              = dout_ff;
   assign freq_target_out   = target_ff;
   assign brake_release_out = release_ff;
   assign brake_fault_out   = fault_ff;
   assign fault_code_out    = code_ff;
endmodule // mbs_motor_brake_sequencer
`default_nettype wire

// [shared/mbs_pkg.sv]
`default_nettype none
package mbs_pkg;
   // clocking and sequence timer base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_MS       = 10;
   localparam int unsigned TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned PRE_W         = 20;
   localparam int unsigned DELAY_MAX_S   = 5;
   // bus and datapath widths
   localparam int unsigned DW     = 16;
   localparam int unsigned AW     = 6;
   localparam int unsigned FW     = 8;
   localparam int unsigned N_DIN  = 8;
   localparam int unsigned N_DOUT = 5;
   // setting limits: delays in 10 ms ticks, frequency in 0.1 Hz
   localparam logic [DW-1:0] DELAY_MAX_TICKS = DW'(DELAY_MAX_S * 1000 / TICK_MS);
   localparam logic [DW-1:0] FREQ_MAX        = 16'h0fa0;
   localparam logic [DW-1:0] FREQ_ZERO       = 16'h0000;
   localparam logic [DW-1:0] RATED_CURRENT   = 16'h0064;
   localparam logic [DW-1:0] DELAY_RST       = 16'h0000;
   // register offsets
   localparam logic [AW-1:0] A_CTRL     = 6'h00;
   localparam logic [AW-1:0] A_REL_DLY  = 6'h01;
   localparam logic [AW-1:0] A_ACC_DLY  = 6'h02;
   localparam logic [AW-1:0] A_STOP_DLY = 6'h03;
   localparam logic [AW-1:0] A_CONF_TO  = 6'h04;
   localparam logic [AW-1:0] A_BFREQ    = 6'h05;
   localparam logic [AW-1:0] A_CUR_MIN  = 6'h06;
   localparam logic [AW-1:0] A_SETPT    = 6'h07;
   localparam logic [AW-1:0] A_STATUS   = 6'h08;
   localparam logic [AW-1:0] A_IN_FN    = 6'h10;
   localparam logic [AW-1:0] A_OUT_FN   = 6'h18;
   // codes
   localparam logic [FW-1:0] CTRL_OFF     = 8'h00;
   localparam logic [FW-1:0] CTRL_ON      = 8'h01;
   localparam logic [FW-1:0] FN_NONE      = 8'h00;
   localparam logic [FW-1:0] FN_CONFIRM   = 8'h2c;
   localparam logic [FW-1:0] FN_RELEASE   = 8'h13;
   localparam logic [FW-1:0] FN_FAULT     = 8'h14;
   localparam logic [FW-1:0] CODE_NONE    = 8'h00;
   localparam logic [FW-1:0] CODE_RELEASE = 8'h20;
   localparam logic [FW-1:0] CODE_APPLY   = 8'h24;
   // status register fields
   localparam int unsigned ST_REL_BIT   = 0;
   localparam int unsigned ST_FLT_BIT   = 1;
   localparam int unsigned ST_CONF_BIT  = 2;
   localparam int unsigned ST_STATE_LSB = 4;
   localparam int unsigned ST_CODE_LSB  = 8;
   localparam int unsigned CLR_BIT      = 0;
   typedef enum logic [3:0] {
      MBS_IDLE, MBS_PLAIN, MBS_ACC_BRK, MBS_REL_WAIT, MBS_CONF_REL, MBS_ACC_WAIT,
      MBS_RUN, MBS_DEC_BRK, MBS_CONF_APPLY, MBS_STOP_WAIT, MBS_DEC_ZERO, MBS_FAULT
   } mbs_state_t;
endpackage
`default_nettype wire

// [test/mbs_brake_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mbs_brake_model #(
   parameter int unsigned LAG = 3
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic release_in,
   input  wire logic stuck,
   output logic      confirm_out
);
   logic [7:0] cnt_ff;
   // contact follows the coil after a mechanical lag; stuck models a seized brake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff      <= 8'h00;
         confirm_out <= 1'b0;
      end else if (stuck || release_in == confirm_out) begin
         cnt_ff <= 8'h00;
      end else if (cnt_ff == 8'(LAG - 1)) begin
         confirm_out <= release_in;
         cnt_ff      <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule // mbs_brake_model
`default_nettype wire

// [test/mbs_motor_brake_sequencer_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module mbs_motor_brake_sequencer_chk #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic [mbs_pkg::AW-1:0]     reg_addr,
   input wire logic [mbs_pkg::DW-1:0]     reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [mbs_pkg::DW-1:0]     reg_rdata,
   input wire logic                       run_cmd,
   input wire logic [mbs_pkg::DW-1:0]     out_freq_in,
   input wire logic [mbs_pkg::DW-1:0]     motor_current_in,
   input wire logic [mbs_pkg::N_DIN-1:0]  din,
   input wire logic [mbs_pkg::N_DOUT-1:0] dout,
   input wire logic [mbs_pkg::DW-1:0]     freq_target_out,
   input wire logic                       brake_release_out,
   input wire logic                       brake_fault_out,
   input wire logic [mbs_pkg::FW-1:0]     fault_code_out
);
   logic [mbs_pkg::DW-1:0] cur_min_ff;
   // shadow of the minimum current, clamped the way the register clamps it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_min_ff <= mbs_pkg::RATED_CURRENT;
      end else if (reg_wr && reg_addr == mbs_pkg::A_CUR_MIN) begin
         cur_min_ff <= (reg_wdata > 16'h00c8) ? 16'h00c8 : reg_wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   flt_no_rel_a: assert property (brake_fault_out |-> !brake_release_out)
      else $error("release high during fault");
   flt_tgt_zero_a: assert property (brake_fault_out |=> freq_target_out == 16'h0000)
      else $error("target not zero in fault");
   // run request as it stood at the edge that decided the fault, not one later
   code_apply_a: assert property ($rose(brake_fault_out) && !$past(run_cmd) |->
      fault_code_out == mbs_pkg::CODE_APPLY) else $error("wrong apply code");
   code_release_a: assert property ($rose(brake_fault_out) && $past(run_cmd) |->
      fault_code_out == mbs_pkg::CODE_RELEASE) else $error("wrong release code");
   flt_hold_a: assert property (brake_fault_out
      && !(reg_wr && reg_addr == mbs_pkg::A_STATUS)
      |=> brake_fault_out) else $error("fault dropped uncleared");
   rel_at_freq_a: assert property ($rose(brake_release_out) |->
      $past(out_freq_in) == $past(freq_target_out)) else $error("release off frequency");
   rel_current_a: assert property ($rose(brake_release_out) |->
      $past(motor_current_in) >= cur_min_ff) else $error("release below current");
   rel_fall_a: assert property ($fell(brake_release_out) |-> brake_fault_out || !run_cmd)
      else $error("release dropped while running");
   hold_freq_a: assert property ($fell(brake_release_out) && !brake_fault_out |=>
      $stable(freq_target_out)) else $error("frequency moved after apply");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
endmodule // mbs_motor_brake_sequencer_chk
bind mbs_motor_brake_sequencer mbs_motor_brake_sequencer_chk #(
   .TICK_CYCLES(TICK_CYCLES)
) u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_cmd(run_cmd),
   .out_freq_in(out_freq_in), .motor_current_in(motor_current_in), .din(din),
   .dout(dout), .freq_target_out(freq_target_out), .brake_release_out(brake_release_out),
   .brake_fault_out(brake_fault_out), .fault_code_out(fault_code_out)
);
`default_nettype wire

// [test/tb_mbs_motor_brake_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %0t: line %0d got %0h", $time, `__LINE__, g); end end
`define WAIT(c) begin waited = 0; while (!(c) && waited < 600) begin \
   @(posedge clk); #1; waited++; end \
   if (!(c)) begin bad_count++; $display("MISMATCH %0t: wait timed out", $time); end end
module tb_mbs_motor_brake_sequencer;
   localparam int unsigned TICK = 4;
   localparam int unsigned LAG  = 3;
   localparam logic [15:0] BFREQ = 16'h0100;
   localparam logic [15:0] SETPT = 16'h0200;
   logic        clk, rst_n, reg_wr, reg_rd, run_cmd, stuck, confirm;
   logic        brake_release_out, brake_fault_out;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, out_freq_in, motor_current_in, freq_target_out;
   logic [7:0]  din, fault_code_out;
   logic [4:0]  dout;
   int          bad_count, tests_run, waited;
   assign din = {5'h00, confirm, 2'b00};
   mbs_motor_brake_sequencer #(.TICK_CYCLES(TICK)) u_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_cmd(run_cmd),
      .out_freq_in(out_freq_in), .motor_current_in(motor_current_in), .din(din),
      .dout(dout), .freq_target_out(freq_target_out), .brake_release_out(brake_release_out),
      .brake_fault_out(brake_fault_out), .fault_code_out(fault_code_out));
   mbs_brake_model #(.LAG(LAG)) u_brake (.clk(clk), .rst_n(rst_n), .release_in(dout[0]),
      .stuck(stuck), .confirm_out(confirm));
   // clock and a ramp generator that settles one cycle after each target
   always #5 clk = ~clk;
   always @(posedge clk) out_freq_in <= freq_target_out;
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic setup(input logic [15:0] rel, acc, stp, cto);
      wr(mbs_pkg::A_REL_DLY, rel);
      wr(mbs_pkg::A_ACC_DLY, acc);
      wr(mbs_pkg::A_STOP_DLY, stp);
      wr(mbs_pkg::A_CONF_TO, cto);
   endtask
   // clearing is only honoured with the run request low
   task automatic clear_fault();
      run_cmd <= 1'b0;
      stuck   <= 1'b0;
      wr(mbs_pkg::A_STATUS, 16'h0001);
      `WAIT(brake_fault_out === 1'b0)
      `CHK(brake_fault_out, 1'b0)
      `WAIT(confirm === 1'b0)
   endtask
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      bad_count++;
      $display("MISMATCH %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      {clk, rst_n, reg_wr, reg_rd, run_cmd, stuck} = 6'b000000;
      {reg_addr, reg_wdata, out_freq_in} = '0;
      motor_current_in = 16'h0080;
      bad_count = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk); #1;
      rd(mbs_pkg::A_CTRL, 16'h0000);
      rd(mbs_pkg::A_CUR_MIN, mbs_pkg::RATED_CURRENT);
      rd(mbs_pkg::A_REL_DLY, 16'h0000);
      rd(mbs_pkg::A_ACC_DLY, 16'h0000);
      wr(6'h3f, 16'h1234);
      rd(6'h3f, 16'h0000);
      wr(mbs_pkg::A_BFREQ, 16'h1000);
      rd(mbs_pkg::A_BFREQ, mbs_pkg::FREQ_MAX);
      wr(mbs_pkg::A_STOP_DLY, 16'h0258);
      rd(mbs_pkg::A_STOP_DLY, mbs_pkg::DELAY_MAX_TICKS);
      done("registers");
      wr(mbs_pkg::A_IN_FN + 6'h02, {8'h00, mbs_pkg::FN_CONFIRM});
      wr(mbs_pkg::A_OUT_FN, {8'h00, mbs_pkg::FN_RELEASE});
      wr(mbs_pkg::A_OUT_FN + 6'h01, {8'h00, mbs_pkg::FN_FAULT});
      wr(mbs_pkg::A_BFREQ, BFREQ);
      wr(mbs_pkg::A_SETPT, SETPT);
      setup(16'h0002, 16'h0001, 16'h0001, 16'h0005);
      run_cmd <= 1'b1;
      repeat (30) @(posedge clk); #1;
      `CHK(brake_release_out, 1'b0)
      rd(mbs_pkg::A_STATUS, 16'h0010);
      run_cmd <= 1'b0;
      repeat (5) @(posedge clk); #1;
      wr(mbs_pkg::A_CTRL, {8'h00, mbs_pkg::CTRL_ON});
      done("disabled");
      run_cmd <= 1'b1;
      `WAIT(freq_target_out === BFREQ)
      `CHK(freq_target_out, BFREQ)
      `WAIT(brake_release_out === 1'b1)
      `CHK(waited >= 2 * TICK, 1'b1)
      `WAIT(freq_target_out === SETPT)
      `CHK(waited >= LAG + TICK, 1'b1)
      `CHK(dout[1:0], 2'b01)
      run_cmd <= 1'b0;
      `WAIT(freq_target_out === BFREQ)
      `CHK(freq_target_out, BFREQ)
      `WAIT(brake_release_out === 1'b0)
      `CHK(freq_target_out, BFREQ)
      `WAIT(freq_target_out === 16'h0000)
      `CHK(waited >= LAG + TICK, 1'b1)
      `CHK(brake_fault_out, 1'b0)
      repeat (4) @(posedge clk); #1;
      rd(mbs_pkg::A_STATUS, 16'h0000);
      done("start and stop");
      run_cmd <= 1'b1;
      `WAIT(freq_target_out === SETPT)
      stuck   <= 1'b1;
      run_cmd <= 1'b0;
      `WAIT(brake_release_out === 1'b0)
      `WAIT(brake_fault_out === 1'b1)
      `CHK(waited >= 5 * TICK, 1'b1)
      `CHK(fault_code_out, mbs_pkg::CODE_APPLY)
      @(posedge clk); #1;
      `CHK(dout[1:0], 2'b10)
      clear_fault();
      done("apply timeout");
      setup(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      stuck   <= 1'b1;
      run_cmd <= 1'b1;
      `WAIT(brake_fault_out === 1'b1)
      `CHK(fault_code_out, mbs_pkg::CODE_RELEASE)
      `CHK(brake_release_out, 1'b0)
      clear_fault();
      done("release timeout");
      wr(mbs_pkg::A_CONF_TO, 16'h0005);
      motor_current_in <= 16'h0010;
      run_cmd <= 1'b1;
      `WAIT(brake_fault_out === 1'b1)
      `CHK(fault_code_out, mbs_pkg::CODE_RELEASE)
      // routed pins follow the flags one cycle later
      @(posedge clk); #1;
      `CHK(dout[1:0], 2'b10)
      clear_fault();
      done("low current");
      end_sim();
   end
endmodule // tb_mbs_motor_brake_sequencer
`default_nettype wire
